// ### hdl/hpsd_pkg.sv
// Constants for the host port select and default configuration block.
// Assumes one 25 MHz clock and an asynchronous active-high reset.
//
// Overview of operation
// - Two-wire port is Fast-mode slave, 400 kb/s max.
// - Strap low enables clocked serial, disables two-wire.
// - Clocked serial port is slave, only with strap low.
// - Both async ports reset to 38400 8N1.
// - Primary sends default NMEA set, binary protocol quiet.
// - Primary accepts binary, NMEA, RTCM input.
// - No RTCM output on either async port.
// - Secondary NMEA off by default, binary output impossible.
// - Secondary takes RTCM input, never binary input.
// - USB, two-wire, clocked serial mirror primary defaults.
package hpsd_pkg;

	// Framing defaults
	localparam logic [19:0] BAUD_DEFAULT = 20'h09600;
	localparam logic [3:0] DATA_BITS_DEFAULT = 4'h8;
	localparam logic [1:0] PARITY_NONE = 2'h0;
	localparam logic [1:0] STOP_BITS_DEFAULT = 2'h1;

	// Two-wire port limits
	localparam int unsigned TWO_WIRE_MAX_KBPS = 400;
	localparam int unsigned CLK_KHZ = 25000;
	localparam int unsigned TWO_WIRE_MIN_BIT_CYCLES = (CLK_KHZ + TWO_WIRE_MAX_KBPS - 1) / TWO_WIRE_MAX_KBPS;

	// NMEA message mask bit positions
	localparam int unsigned NMEA_GGA = 0;
	localparam int unsigned NMEA_GLL = 1;
	localparam int unsigned NMEA_GSA = 2;
	localparam int unsigned NMEA_GSV = 3;
	localparam int unsigned NMEA_RMC = 4;
	localparam int unsigned NMEA_VTG = 5;
	localparam int unsigned NMEA_TXT = 6;
	localparam logic [6:0] NMEA_MSG_DEFAULT = 7'h7F;
	localparam logic [6:0] NMEA_MSG_NONE = 7'h00;

	// Protocol mask bit positions: binary, NMEA, RTCM
	localparam int unsigned PROTO_BIN = 0;
	localparam int unsigned PROTO_NMEA = 1;
	localparam int unsigned PROTO_RTCM = 2;
	localparam logic [2:0] PRI_IN_DEFAULT = 3'h7;
	localparam logic [2:0] PRI_IN_ALLOWED = 3'h7;
	localparam logic [2:0] PRI_OUT_DEFAULT = 3'h3;
	localparam logic [2:0] PRI_OUT_ALLOWED = 3'h3;
	localparam logic [2:0] SEC_IN_DEFAULT = 3'h4;
	localparam logic [2:0] SEC_IN_ALLOWED = 3'h6;
	localparam logic [2:0] SEC_OUT_DEFAULT = 3'h0;
	localparam logic [2:0] SEC_OUT_ALLOWED = 3'h2;
	localparam logic [7:0] BIN_MSG_DEFAULT = 8'h00;

	// Port indices
	localparam int unsigned PORT_PRI = 0;
	localparam int unsigned PORT_SEC = 1;
	localparam int unsigned PORT_USB = 2;
	localparam int unsigned PORT_TWI = 3;
	localparam int unsigned PORT_SPI = 4;
	localparam int unsigned NUM_PORTS = 5;

	typedef enum logic [1:0] {
		HPSD_ST_RESET,
		HPSD_ST_STRAP,
		HPSD_ST_RUN
	} hpsd_state_type;

endpackage

// ### hdl/hpsd_port_cfg.sv
// One port's configuration store: framing and protocol masks.
// Assumes writes arrive as single-cycle strobes from the host side.
`timescale 1ns/1ps
module hpsd_port_cfg #(
	parameter logic [2:0] IN_DEFAULT = 3'h7,
	parameter logic [2:0] IN_ALLOWED = 3'h7,
	parameter logic [2:0] OUT_DEFAULT = 3'h3,
	parameter logic [2:0] OUT_ALLOWED = 3'h3,
	parameter logic [6:0] NMEA_DEFAULT = 7'h7F
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_we,
	input wire logic [19:0] cfg_baud,
	input wire logic [2:0] cfg_in_proto,
	input wire logic [2:0] cfg_out_proto,
	input wire logic [6:0] cfg_nmea_msgs,
	output logic [19:0] baud,
	output logic [3:0] data_bits,
	output logic [1:0] parity,
	output logic [1:0] stop_bits,
	output logic [2:0] in_proto,
	output logic [2:0] out_proto,
	output logic [6:0] nmea_msgs,
	output logic [7:0] bin_msgs
);

	typedef struct packed {
		logic [19:0] baud;
		logic [2:0] in_proto;
		logic [2:0] out_proto;
		logic [6:0] nmea;
	} hpsd_cfg_type;

	hpsd_cfg_type s_q;
	hpsd_cfg_type s_d;

	always_comb begin
		s_d = s_q;
		if (cfg_we) begin
			s_d.baud = cfg_baud;
			s_d.in_proto = cfg_in_proto & IN_ALLOWED;
			s_d.out_proto = cfg_out_proto & OUT_ALLOWED;
			s_d.nmea = cfg_nmea_msgs;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q.baud <= hpsd_pkg::BAUD_DEFAULT;
			s_q.in_proto <= IN_DEFAULT;
			s_q.out_proto <= OUT_DEFAULT;
			s_q.nmea <= NMEA_DEFAULT;
		end else begin
			s_q <= s_d;
		end
	end

	assign baud = s_q.baud;
	assign data_bits = hpsd_pkg::DATA_BITS_DEFAULT;
	assign parity = hpsd_pkg::PARITY_NONE;
	assign stop_bits = hpsd_pkg::STOP_BITS_DEFAULT;
	assign in_proto = s_q.in_proto;
	assign out_proto = s_q.out_proto;
	assign nmea_msgs = s_q.nmea;
	assign bin_msgs = hpsd_pkg::BIN_MSG_DEFAULT;

endmodule

// ### hdl/hpsd_top.sv
// Host port selection and default protocol configuration.
// Assumes the strap is stable around reset release and inputs are synchronous to clk.
`timescale 1ns/1ps
module hpsd_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic sel_strap,
	input wire logic [4:0] cfg_we,
	input wire logic [19:0] cfg_baud,
	input wire logic [2:0] cfg_in_proto,
	input wire logic [2:0] cfg_out_proto,
	input wire logic [6:0] cfg_nmea_msgs,
	output logic spi_en,
	output logic twi_en,
	output logic [7:0] twi_min_bit_cycles,
	output logic cfg_ready,
	output logic [99:0] port_baud,
	output logic [19:0] port_data_bits,
	output logic [9:0] port_parity,
	output logic [9:0] port_stop_bits,
	output logic [14:0] port_in_proto,
	output logic [14:0] port_out_proto,
	output logic [34:0] port_nmea_msgs,
	output logic [39:0] port_bin_msgs
);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		hpsd_pkg::hpsd_state_type st;
		logic spi;
		logic twi;
	} hpsd_top_type;

	hpsd_top_type s_q;
	hpsd_top_type s_d;

	always_comb begin
		s_d = s_q;
		case (s_q.st)
			hpsd_pkg::HPSD_ST_RESET: begin
				s_d.st = hpsd_pkg::HPSD_ST_STRAP;
			end
			hpsd_pkg::HPSD_ST_STRAP: begin
				s_d.spi = ~sel_strap;
				s_d.twi = sel_strap;
				s_d.st = hpsd_pkg::HPSD_ST_RUN;
			end
			hpsd_pkg::HPSD_ST_RUN: begin
				s_d.st = hpsd_pkg::HPSD_ST_RUN;
			end
			default: begin
				s_d.st = hpsd_pkg::HPSD_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q.st <= hpsd_pkg::HPSD_ST_RESET;
			s_q.spi <= 1'b0;
			s_q.twi <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign spi_en = s_q.spi;
	assign twi_en = s_q.twi;
	assign cfg_ready = (s_q.st == hpsd_pkg::HPSD_ST_RUN);
	assign twi_min_bit_cycles = 8'(hpsd_pkg::TWO_WIRE_MIN_BIT_CYCLES);

	////////////////////////////////////////////////////////////////////////
	// Port defaults and limits by port index

	function automatic logic [2:0] in_default(input int unsigned idx);
		case (idx)
			hpsd_pkg::PORT_PRI: begin
				return hpsd_pkg::PRI_IN_DEFAULT;
			end
			hpsd_pkg::PORT_SEC: begin
				return hpsd_pkg::SEC_IN_DEFAULT;
			end
			hpsd_pkg::PORT_USB: begin
				return hpsd_pkg::PRI_IN_DEFAULT;
			end
			hpsd_pkg::PORT_TWI: begin
				return hpsd_pkg::PRI_IN_DEFAULT;
			end
			hpsd_pkg::PORT_SPI: begin
				return hpsd_pkg::PRI_IN_DEFAULT;
			end
			default: begin
				return hpsd_pkg::PRI_IN_DEFAULT;
			end
		endcase
	endfunction

	function automatic logic [2:0] in_allowed(input int unsigned idx);
		case (idx)
			hpsd_pkg::PORT_PRI: begin
				return hpsd_pkg::PRI_IN_ALLOWED;
			end
			hpsd_pkg::PORT_SEC: begin
				return hpsd_pkg::SEC_IN_ALLOWED;
			end
			hpsd_pkg::PORT_USB: begin
				return hpsd_pkg::PRI_IN_ALLOWED;
			end
			hpsd_pkg::PORT_TWI: begin
				return hpsd_pkg::PRI_IN_ALLOWED;
			end
			hpsd_pkg::PORT_SPI: begin
				return hpsd_pkg::PRI_IN_ALLOWED;
			end
			default: begin
				return hpsd_pkg::PRI_IN_ALLOWED;
			end
		endcase
	endfunction

	function automatic logic [2:0] out_default(input int unsigned idx);
		case (idx)
			hpsd_pkg::PORT_PRI: begin
				return hpsd_pkg::PRI_OUT_DEFAULT;
			end
			hpsd_pkg::PORT_SEC: begin
				return hpsd_pkg::SEC_OUT_DEFAULT;
			end
			hpsd_pkg::PORT_USB: begin
				return hpsd_pkg::PRI_OUT_DEFAULT;
			end
			hpsd_pkg::PORT_TWI: begin
				return hpsd_pkg::PRI_OUT_DEFAULT;
			end
			hpsd_pkg::PORT_SPI: begin
				return hpsd_pkg::PRI_OUT_DEFAULT;
			end
			default: begin
				return hpsd_pkg::PRI_OUT_DEFAULT;
			end
		endcase
	endfunction

	function automatic logic [2:0] out_allowed(input int unsigned idx);
		case (idx)
			hpsd_pkg::PORT_PRI: begin
				return hpsd_pkg::PRI_OUT_ALLOWED;
			end
			hpsd_pkg::PORT_SEC: begin
				return hpsd_pkg::SEC_OUT_ALLOWED;
			end
			hpsd_pkg::PORT_USB: begin
				return hpsd_pkg::PRI_OUT_ALLOWED;
			end
			hpsd_pkg::PORT_TWI: begin
				return hpsd_pkg::PRI_OUT_ALLOWED;
			end
			hpsd_pkg::PORT_SPI: begin
				return hpsd_pkg::PRI_OUT_ALLOWED;
			end
			default: begin
				return hpsd_pkg::PRI_OUT_ALLOWED;
			end
		endcase
	endfunction

	function automatic logic [6:0] nmea_default(input int unsigned idx);
		case (idx)
			hpsd_pkg::PORT_PRI: begin
				return hpsd_pkg::NMEA_MSG_DEFAULT;
			end
			hpsd_pkg::PORT_SEC: begin
				return hpsd_pkg::NMEA_MSG_NONE;
			end
			hpsd_pkg::PORT_USB: begin
				return hpsd_pkg::NMEA_MSG_DEFAULT;
			end
			hpsd_pkg::PORT_TWI: begin
				return hpsd_pkg::NMEA_MSG_DEFAULT;
			end
			hpsd_pkg::PORT_SPI: begin
				return hpsd_pkg::NMEA_MSG_DEFAULT;
			end
			default: begin
				return hpsd_pkg::NMEA_MSG_DEFAULT;
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Per-port configuration

	genvar g;
	generate
		for (g = 0; g < hpsd_pkg::NUM_PORTS; g = g + 1) begin : gen_port
			hpsd_port_cfg #(
				.IN_DEFAULT(in_default(g)),
				.IN_ALLOWED(in_allowed(g)),
				.OUT_DEFAULT(out_default(g)),
				.OUT_ALLOWED(out_allowed(g)),
				.NMEA_DEFAULT(nmea_default(g))
			) u_cfg (
				.clk(clk),
				.rst(rst),
				.cfg_we(cfg_we[g] & cfg_ready),
				.cfg_baud(cfg_baud),
				.cfg_in_proto(cfg_in_proto),
				.cfg_out_proto(cfg_out_proto),
				.cfg_nmea_msgs(cfg_nmea_msgs),
				.baud(port_baud[g*20 +: 20]),
				.data_bits(port_data_bits[g*4 +: 4]),
				.parity(port_parity[g*2 +: 2]),
				.stop_bits(port_stop_bits[g*2 +: 2]),
				.in_proto(port_in_proto[g*3 +: 3]),
				.out_proto(port_out_proto[g*3 +: 3]),
				.nmea_msgs(port_nmea_msgs[g*7 +: 7]),
				.bin_msgs(port_bin_msgs[g*8 +: 8])
			);
		end
	endgenerate

endmodule

// ### sim/hpsd_host.sv
// Host side model: sets the interface strap.
// Assumes the bench picks the strap level while reset is held.
`timescale 1ns/1ps
module hpsd_host (
	input wire logic clk,
	input wire logic rst,
	input wire logic want,
	output logic sel_strap
);
	// Strap changes only under reset, then stays put
	always @(posedge clk or posedge rst) begin
		if (rst) sel_strap <= want;
	end
endmodule

// ### sim/hpsd_props.sv
// Checker for the host port select block.
// Assumes it is bound to hpsd_top and sees only its ports.
`timescale 1ns/1ps
module hpsd_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic sel_strap,
	input wire logic [4:0] cfg_we,
	input wire logic [2:0] cfg_out_proto,
	input wire logic spi_en,
	input wire logic twi_en,
	input wire logic [7:0] twi_min_bit_cycles,
	input wire logic cfg_ready,
	input wire logic [19:0] port_data_bits,
	input wire logic [9:0] port_parity,
	input wire logic [9:0] port_stop_bits,
	input wire logic [14:0] port_in_proto,
	input wire logic [14:0] port_out_proto,
	input wire logic [39:0] port_bin_msgs
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	sel_excl_a: assert property (cfg_ready |-> spi_en != twi_en) else $error("enables clash");
	spi_strap_a: assert property ($rose(cfg_ready) |-> spi_en == !sel_strap) else $error("strap wrong");
	idle_off_a: assert property (!cfg_ready |-> !spi_en && !twi_en) else $error("early enable");
	enable_hold_a: assert property (
		cfg_ready && $past(cfg_ready) |-> $stable(spi_en) && $stable(twi_en)) else $error("moved");
	twi_rate_a: assert property (twi_min_bit_cycles == 8'h3F) else $error("bit cycles wrong");
	framing_a: assert property (
		{port_data_bits, port_parity, port_stop_bits} == {20'h88888, 10'h000, 10'h155}) else $error("framing wrong");
	no_rtcm_a: assert property ((port_out_proto & 15'h4924) == 15'h0000) else $error("rtcm out");
	sec_bin_a: assert property (!port_in_proto[3] && !port_out_proto[3]) else $error("sec binary");
	pri_write_a: assert property (
		cfg_ready && cfg_we[0] |=> port_out_proto[2:0] == ($past(cfg_out_proto) & 3'h3))
		else $error("pri write wrong");
	bin_quiet_a: assert property (port_bin_msgs == 40'h0) else $error("binary msgs on");
	cover property (cfg_ready && cfg_we == 5'h1F);
	cover property (spi_en);
	cover property (twi_en);
endmodule
bind hpsd_top hpsd_props u_props (.clk(clk), .rst(rst), .sel_strap(sel_strap), .cfg_we(cfg_we),
	.cfg_out_proto(cfg_out_proto), .spi_en(spi_en), .twi_en(twi_en), .twi_min_bit_cycles(twi_min_bit_cycles),
	.cfg_ready(cfg_ready), .port_data_bits(port_data_bits), .port_parity(port_parity),
	.port_stop_bits(port_stop_bits), .port_in_proto(port_in_proto), .port_out_proto(port_out_proto),
	.port_bin_msgs(port_bin_msgs));

// ### sim/host_port_select_defaults_test.sv
// Testbench for the host port select block.
// Assumes the host model supplies the strap.
`timescale 1ns/1ps
module host_port_select_defaults_test;
	logic clk = 0, rst = 1, want = 0, sel_strap, spi_en, twi_en, cfg_ready;
	logic [4:0] we = 0;
	logic [19:0] baud = 0, pdb;
	logic [2:0] ip = 0, op = 0;
	logic [6:0] nm = 0;
	logic [7:0] tmb;
	logic [99:0] pb;
	logic [9:0] ppa, pst;
	logic [14:0] pin, pout;
	logic [34:0] pnm;
	logic [39:0] pbm;
	logic [19:0] eb[5];
	logic [2:0] ei[5], eo[5];
	logic [6:0] en[5];
	int fails = 0, checked = 0;
	always #20 clk = ~clk;
	hpsd_host host (.clk(clk), .rst(rst), .want(want), .sel_strap(sel_strap));
	hpsd_top dut (.clk(clk), .rst(rst), .sel_strap(sel_strap), .cfg_we(we), .cfg_baud(baud), .cfg_in_proto(ip),
		.cfg_out_proto(op), .cfg_nmea_msgs(nm), .spi_en(spi_en), .twi_en(twi_en), .twi_min_bit_cycles(tmb),
		.cfg_ready(cfg_ready), .port_baud(pb), .port_data_bits(pdb), .port_parity(ppa), .port_stop_bits(pst),
		.port_in_proto(pin), .port_out_proto(pout), .port_nmea_msgs(pnm), .port_bin_msgs(pbm));
	////////////////////////////////////////////////////////////////
	task cmp(string s, logic [99:0] e, logic [99:0] g);
		checked++;
		if (e !== g) begin
			fails++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task print_verdict;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	function automatic logic [2:0] exp_in(int g, logic [2:0] v);
		return v & ((g == 1) ? 3'h6 : 3'h7);
	endfunction
	function automatic logic [2:0] exp_out(int g, logic [2:0] v);
		return v & ((g == 1) ? 3'h2 : 3'h3);
	endfunction
	task check_ports;
		for (int g = 0; g < 5; g++) begin
			cmp("baud", eb[g], pb[g*20+:20]);
			cmp("in_proto", ei[g], pin[g*3+:3]);
			cmp("out_proto", eo[g], pout[g*3+:3]);
			cmp("nmea", en[g], pnm[g*7+:7]);
		end
		cmp("framing", {20'h88888, 10'h000, 10'h155}, {pdb, ppa, pst});
		cmp("bin_msgs", 40'h0, pbm);
	endtask
	task do_reset(logic s);
		int n;
		want = s;
		rst = 1;
		we = 5'h1F;
		op = 3'h0;
		repeat (20) @(posedge clk);
		#1 rst = 0;
		repeat (2) @(posedge clk);
		#1 we = 0;
		cmp("cfg_ready", 1'b1, cfg_ready);
		n = 0;
		while (cfg_ready !== 1'b1 && n < 10) begin
			@(posedge clk);
			#1 n++;
		end
		if (cfg_ready !== 1'b1) begin
			fails++;
			print_verdict();
		end
		for (int g = 0; g < 5; g++) begin
			eb[g] = 20'h09600;
			ei[g] = (g == 1) ? 3'h4 : 3'h7;
			eo[g] = (g == 1) ? 3'h0 : 3'h3;
			en[g] = (g == 1) ? 7'h00 : 7'h7F;
		end
		cmp("spi_en", !s, spi_en);
		cmp("twi_en", s, twi_en);
		cmp("bit_cycles", 8'h3F, tmb);
		check_ports();
		$display("test reset strap %0d done", s);
	endtask
	task rand_writes(int k);
		for (int i = 0; i < k; i++) begin
			we = (i == 0) ? 5'h1F : 5'($urandom);
			baud = 20'($urandom);
			ip = (i == 0) ? 3'h7 : 3'($urandom);
			op = (i == 0) ? 3'h7 : 3'($urandom);
			nm = 7'($urandom);
			@(posedge clk);
			for (int g = 0; g < 5; g++) if (we[g]) begin
				eb[g] = baud;
				ei[g] = exp_in(g, ip);
				eo[g] = exp_out(g, op);
				en[g] = nm;
			end
			#1 check_ports();
		end
		we = 0;
		@(posedge clk);
		#1 check_ports();
		$display("test random writes done");
	endtask
	initial begin
		void'($urandom(32'h06619246));
		do_reset(1'b0);
		rand_writes(40);
		do_reset(1'b1);
		rand_writes(20);
		print_verdict();
	end
endmodule
